// ---- hdl/sensor_regs_map.svh ----
// offsets, field positions and reset values of the sensor register bank
// assumes byte address = 4 * register index on the bus
`ifndef SENSOR_REGS_MAP_SVH
`define SENSOR_REGS_MAP_SVH

// register indices
`define IDX_ALARM_STATUS 6'h00
`define IDX_ALARM_MASK 6'h01
`define IDX_FILL_COUNT 6'h07
`define IDX_READ_PORT 6'h08
`define IDX_CFG_ONE 6'h09
`define IDX_CFG_TWO 6'h0A
`define IDX_SYS_CTRL 6'h0C
`define IDX_UPPER_HIGH 6'h10
`define IDX_UPPER_LOW 6'h11
`define IDX_LOWER_HIGH 6'h12
`define IDX_LOWER_LOW 6'h13

// reset values
`define RST_ALARM_MASK 8'h00
`define RST_CFG_ONE 8'h0F
`define RST_CFG_TWO 8'h00
`define RST_SYS_CTRL 1'b0
`define RST_UPPER_HIGH 8'h7F
`define RST_UPPER_LOW 8'hFF
`define RST_LOWER_HIGH 8'h80
`define RST_LOWER_LOW 8'h00

// field positions and writable masks
`define BIT_SOFT_RESET 0
`define BIT_OVER_LIMIT 1
`define BIT_UNDER_LIMIT 2
`define BIT_ROLLOVER 1
`define BIT_AFULL_TYPE 2
`define BIT_READ_CLEARS 3
`define BIT_FLUSH 4
`define MASK_CFG_ONE 8'h1F
`define MASK_CFG_TWO 8'h1E
`define MASK_ALARM_BITS 8'h06

`endif

// ---- hdl/sensor_regs_pkg.sv ----
// types shared by the sensor register bank and its neighbours
// assumes nothing beyond a SystemVerilog compiler
package sensor_regs_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_e;

	typedef struct packed {
		logic signed [15:0] upper;
		logic signed [15:0] lower;
	} limits_s;

	typedef struct packed {
		logic [4:0] almostFullLevel;
		logic flush;
		logic queueReadClearsFlags;
		logic almostFullType;
		logic queueRollover;
	} queue_cfg_s;

endpackage

// ---- hdl/alarm_compare.sv ----
// signed comparison of a fresh measurement against both alarm limits
// assumes sample and valid come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module alarm_compare
	import sensor_regs_pkg::*;
(
	input wire logic sampleValid,
	input wire logic signed [15:0] sampleValue,
	input wire limits_s limits,
	output logic overEvent,
	output logic underEvent
);

	always_comb begin
		overEvent = sampleValid && (sampleValue > limits.upper);
		underEvent = sampleValid && (sampleValue < limits.lower);
	end

endmodule
`default_nettype wire

// ---- hdl/event_status.sv ----
// sticky event bits with enable mask and one level interrupt
// assumes set, clear and mask inputs are on the same clock
`timescale 1ns/10ps
`default_nettype none
module event_status #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic softReset,
	input wire logic [WIDTH-1:0] setBits,
	input wire logic [WIDTH-1:0] clearBits,
	input wire logic [WIDTH-1:0] enableBits,
	output logic [WIDTH-1:0] status,
	output logic irq
);

	logic [WIDTH-1:0] status_reg;
	logic [WIDTH-1:0] status_next;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gBit
			// a set arriving with the clear wins
			always_comb begin
				if (softReset) begin
					status_next[i] = 1'b0;
				end else if (setBits[i]) begin
					status_next[i] = 1'b1;
				end else if (clearBits[i]) begin
					status_next[i] = 1'b0;
				end else begin
					status_next[i] = status_reg[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	assign status = status_reg;
	assign irq = |(status_reg & enableBits);

endmodule
`default_nettype wire

// ---- hdl/sensor_config_alarm_regs.sv ----
// register bank of the sensor: queue config, soft reset, alarm limits
// assumes an Avalon-MM master on ref_clk; byte address = 4 * index
`include "sensor_regs_map.svh"
`timescale 1ns/10ps
`default_nettype none
module sensor_config_alarm_regs
	import sensor_regs_pkg::*;
#(
	parameter int ADDR_WIDTH = 8,
	parameter int FILL_WIDTH = 6
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic tempValid,
	input wire logic signed [15:0] tempValue,
	input wire logic [FILL_WIDTH-1:0] queueFillCount,
	input wire logic [7:0] queueData,
	output logic queueReadPulse,
	output queue_cfg_s queueCfg,
	output limits_s alarmLimits,
	output logic [7:0] alarmStatus,
	output logic irq
);

	// index match, shared by the read and the write decode
	function automatic logic isIdx(
		input logic [ADDR_WIDTH-1:0] addr,
		input logic [5:0] idx
	);
		logic [ADDR_WIDTH-1:0] want;
		want = '0;
		want[7:2] = idx;
		isIdx = (addr == want);
	endfunction

	// bus handshake state
	bus_state_e busState_reg;
	bus_state_e busState_next;
	logic [31:0] readData_reg;
	logic [31:0] readData_next;
	logic request;
	logic accept;
	logic acceptRead;
	logic acceptWrite;

	// configuration state
	byte_t cfgOne_reg;
	byte_t cfgOne_next;
	byte_t cfgTwo_reg;
	byte_t cfgTwo_next;
	byte_t alarmMask_reg;
	byte_t alarmMask_next;
	byte_t upperHigh_reg;
	byte_t upperHigh_next;
	byte_t upperLow_reg;
	byte_t upperLow_next;
	byte_t lowerHigh_reg;
	byte_t lowerHigh_next;
	byte_t lowerLow_reg;
	byte_t lowerLow_next;
	logic softReset_reg;
	logic softReset_next;

	// access strobes; at most one write strobe and one read strobe are high in any cycle
	logic wrSysCtrl;
	logic wrAlarmMask;
	logic wrCfgOne;
	logic wrCfgTwo;
	logic wrUpperHigh;
	logic wrUpperLow;
	logic wrLowerHigh;
	logic wrLowerLow;
	logic wrStatus;
	logic rdStatus;
	logic rdQueuePort;

	// alarm events and status clearing
	logic overLimitFlag;
	logic underLimitFlag;
	logic [7:0] alarmSet;
	logic [7:0] alarmClear;
	logic [7:0] statusBits;
	byte_t readByte;

	assign request = read || write;
	assign accept = request && (busState_reg == BUS_ANSWER);
	assign acceptRead = accept && read;
	assign acceptWrite = accept && write;
	assign waitrequest = request && !accept;

	// answer one cycle after a request is seen; held off during soft reset
	always_comb begin
		busState_next = busState_reg;
		case (busState_reg)
			BUS_IDLE: begin
				if (request && !softReset_reg) begin
					busState_next = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				busState_next = BUS_IDLE;
			end
			default: begin
				busState_next = BUS_IDLE;
			end
		endcase
	end

	// read mux; unmapped and write-only registers read zero
	always_comb begin
		readByte = 8'h00;
		if (isIdx(address, `IDX_ALARM_STATUS)) begin
			readByte = statusBits;
		end else if (isIdx(address, `IDX_ALARM_MASK)) begin
			readByte = alarmMask_reg;
		end else if (isIdx(address, `IDX_FILL_COUNT)) begin
			readByte = 8'(queueFillCount);
		end else if (isIdx(address, `IDX_READ_PORT)) begin
			readByte = queueData;
		end else if (isIdx(address, `IDX_CFG_ONE)) begin
			readByte = cfgOne_reg;
		end else if (isIdx(address, `IDX_CFG_TWO)) begin
			readByte = cfgTwo_reg;
		end else if (isIdx(address, `IDX_UPPER_HIGH)) begin
			readByte = upperHigh_reg;
		end else if (isIdx(address, `IDX_UPPER_LOW)) begin
			readByte = upperLow_reg;
		end else if (isIdx(address, `IDX_LOWER_HIGH)) begin
			readByte = lowerHigh_reg;
		end else if (isIdx(address, `IDX_LOWER_LOW)) begin
			readByte = lowerLow_reg;
		end
	end

	// read data captured when the request is first seen
	always_comb begin
		readData_next = readData_reg;
		if (read && busState_reg == BUS_IDLE && !softReset_reg) begin
			readData_next = {24'h00_0000, readByte};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busState_reg <= BUS_IDLE;
			readData_reg <= 32'h0000_0000;
		end else begin
			busState_reg <= busState_next;
			readData_reg <= readData_next;
		end
	end

	assign readdata = readData_reg;
	assign queueReadPulse = rdQueuePort;

	// write strobes
	// the soft reset cycle never accepts, so strobes stay low in it
	always_comb begin
		wrSysCtrl = acceptWrite && isIdx(address, `IDX_SYS_CTRL);
		wrAlarmMask = acceptWrite && isIdx(address, `IDX_ALARM_MASK);
		wrCfgOne = acceptWrite && isIdx(address, `IDX_CFG_ONE);
		wrCfgTwo = acceptWrite && isIdx(address, `IDX_CFG_TWO);
		wrUpperHigh = acceptWrite && isIdx(address, `IDX_UPPER_HIGH);
		wrUpperLow = acceptWrite && isIdx(address, `IDX_UPPER_LOW);
		wrLowerHigh = acceptWrite && isIdx(address, `IDX_LOWER_HIGH);
		wrLowerLow = acceptWrite && isIdx(address, `IDX_LOWER_LOW);
		wrStatus = acceptWrite && isIdx(address, `IDX_ALARM_STATUS);
	end

	// read strobes, high in the accepting cycle only
	// a read of the queue port pops one byte
	always_comb begin
		rdStatus = acceptRead && isIdx(address, `IDX_ALARM_STATUS);
		rdQueuePort = acceptRead && isIdx(address, `IDX_READ_PORT);
	end

	// soft reset: high for one cycle, then clears itself
	// requests wait out that cycle, so no write races the defaults
	always_comb begin
		softReset_next = `RST_SYS_CTRL;
		if (wrSysCtrl) begin
			softReset_next = writedata[`BIT_SOFT_RESET];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			softReset_reg <= `RST_SYS_CTRL;
		end else begin
			softReset_reg <= softReset_next;
		end
	end

	// queue configuration and alarm enables
	// reserved bits are masked on write, so they read back zero
	always_comb begin
		cfgOne_next = cfgOne_reg;
		cfgTwo_next = cfgTwo_reg;
		alarmMask_next = alarmMask_reg;
		if (softReset_reg) begin
			cfgOne_next = `RST_CFG_ONE;
			cfgTwo_next = `RST_CFG_TWO;
			alarmMask_next = `RST_ALARM_MASK;
		end else begin
			if (wrCfgOne) begin
				cfgOne_next = writedata[7:0] & `MASK_CFG_ONE;
			end
			if (wrCfgTwo) begin
				cfgTwo_next = writedata[7:0] & `MASK_CFG_TWO;
			end
			if (wrAlarmMask) begin
				alarmMask_next = writedata[7:0] & `MASK_ALARM_BITS;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgOne_reg <= `RST_CFG_ONE;
			cfgTwo_reg <= `RST_CFG_TWO;
			alarmMask_reg <= `RST_ALARM_MASK;
		end else begin
			cfgOne_reg <= cfgOne_next;
			cfgTwo_reg <= cfgTwo_next;
			alarmMask_reg <= alarmMask_next;
		end
	end

	// alarm limit bytes; each byte updates alone, so software
	// sees a mixed limit between the two byte writes
	always_comb begin
		upperHigh_next = upperHigh_reg;
		upperLow_next = upperLow_reg;
		lowerHigh_next = lowerHigh_reg;
		lowerLow_next = lowerLow_reg;
		if (softReset_reg) begin
			upperHigh_next = `RST_UPPER_HIGH;
			upperLow_next = `RST_UPPER_LOW;
			lowerHigh_next = `RST_LOWER_HIGH;
			lowerLow_next = `RST_LOWER_LOW;
		end else begin
			if (wrUpperHigh) begin
				upperHigh_next = writedata[7:0];
			end
			if (wrUpperLow) begin
				upperLow_next = writedata[7:0];
			end
			if (wrLowerHigh) begin
				lowerHigh_next = writedata[7:0];
			end
			if (wrLowerLow) begin
				lowerLow_next = writedata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			upperHigh_reg <= `RST_UPPER_HIGH;
			upperLow_reg <= `RST_UPPER_LOW;
			lowerHigh_reg <= `RST_LOWER_HIGH;
			lowerLow_reg <= `RST_LOWER_LOW;
		end else begin
			upperHigh_reg <= upperHigh_next;
			upperLow_reg <= upperLow_next;
			lowerHigh_reg <= lowerHigh_next;
			lowerLow_reg <= lowerLow_next;
		end
	end

	// limits assembled high byte first
	always_comb begin
		alarmLimits.upper = {upperHigh_reg, upperLow_reg};
		alarmLimits.lower = {lowerHigh_reg, lowerLow_reg};
	end

	// queue controls taken from the two configuration registers
	always_comb begin
		queueCfg.almostFullLevel = cfgOne_reg[4:0];
		queueCfg.flush = cfgTwo_reg[`BIT_FLUSH];
		queueCfg.queueReadClearsFlags = cfgTwo_reg[`BIT_READ_CLEARS];
		queueCfg.almostFullType = cfgTwo_reg[`BIT_AFULL_TYPE];
		queueCfg.queueRollover = cfgTwo_reg[`BIT_ROLLOVER];
	end

	// compare runs on every measurement, limits as they stand
	alarm_compare uCompare (
		.sampleValid(tempValid),
		.sampleValue(tempValue),
		.limits(alarmLimits),
		.overEvent(overLimitFlag),
		.underEvent(underLimitFlag)
	);

	// status clears on a read of it, or by writing ones
	always_comb begin
		alarmSet = 8'h00;
		alarmSet[`BIT_OVER_LIMIT] = overLimitFlag;
		alarmSet[`BIT_UNDER_LIMIT] = underLimitFlag;
		alarmClear = 8'h00;
		if (rdStatus) begin
			// clear only the bits this read reported, so an event
			// that lands after the capture is kept
			alarmClear = readData_reg[7:0] & `MASK_ALARM_BITS;
		end else if (wrStatus) begin
			alarmClear = writedata[7:0] & `MASK_ALARM_BITS;
		end
	end

	event_status #(
		.WIDTH(8)
	) uStatus (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.softReset(softReset_reg),
		.setBits(alarmSet),
		.clearBits(alarmClear),
		.enableBits(alarmMask_reg),
		.status(statusBits),
		.irq(irq)
	);

	assign alarmStatus = statusBits;

endmodule
`default_nettype wire

// ---- sim/sensor_regs_monitor.sv ----
// checker for the sensor register bank, bound to its top module
// assumes byte address = 4 * index and a single clock domain
`timescale 1ns/10ps
`default_nettype none
module sensor_regs_monitor
	import sensor_regs_pkg::*;
#(
	parameter int ADDR_WIDTH = 8,
	parameter int FILL_WIDTH = 6
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic tempValid,
	input wire logic signed [15:0] tempValue,
	input wire logic queueReadPulse,
	input wire queue_cfg_s queueCfg,
	input wire limits_s alarmLimits,
	input wire logic [7:0] alarmStatus,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic wrOk;
	logic rdOk;
	assign wrOk = write && !waitrequest;
	assign rdOk = read && !waitrequest;
	chk_soft_defaults: assert property (wrOk && address == 8'h30 &&
		writedata[0] |-> ##2 (alarmLimits == 32'h7fff_8000 &&
		queueCfg == 9'h0f0 && alarmStatus == 8'h00))
		else $error("soft reset left a register off its default");
	chk_sysctl_zero: assert property (rdOk && address == 8'h30
		|-> readdata == 32'h0000_0000) else $error("control reads nonzero");
	chk_upper_high: assert property (wrOk && address == 8'h40
		|=> alarmLimits.upper[15:8] == $past(writedata[7:0]))
		else $error("upper limit high byte not written");
	chk_upper_low: assert property (wrOk && address == 8'h44
		|=> alarmLimits.upper[7:0] == $past(writedata[7:0]))
		else $error("upper limit low byte not written");
	chk_lower_high: assert property (wrOk && address == 8'h48
		|=> alarmLimits.lower[15:8] == $past(writedata[7:0]))
		else $error("lower limit high byte not written");
	chk_lower_low: assert property (wrOk && address == 8'h4c
		|=> alarmLimits.lower[7:0] == $past(writedata[7:0]))
		else $error("lower limit low byte not written");
	chk_reset_limits: assert property ($rose(rst_n)
		|-> alarmLimits == 32'h7fff_8000 && queueCfg == 9'h0f0)
		else $error("limits wrong after reset");
	chk_over_set: assert property (tempValid &&
		tempValue > alarmLimits.upper |=> alarmStatus[1])
		else $error("over flag not set");
	chk_under_set: assert property (tempValid &&
		tempValue < alarmLimits.lower |=> alarmStatus[2])
		else $error("under flag not set");
	chk_read_clears: assert property (rdOk && address == 8'h00 &&
		!tempValid |=> (alarmStatus[2:1] & $past(readdata[2:1])) == 2'b00)
		else $error("status read did not clear flags");
	chk_pop_pulse: assert property (queueReadPulse ==
		(rdOk && address == 8'h20))
		else $error("queue pop pulse wrong");
	chk_irq_quiet: assert property (alarmStatus == 8'h00 |-> !irq)
		else $error("interrupt without status");
endmodule
bind sensor_config_alarm_regs sensor_regs_monitor #(
	.ADDR_WIDTH(ADDR_WIDTH), .FILL_WIDTH(FILL_WIDTH)) mon (.ref_clk, .rst_n,
	.address, .read, .write, .writedata, .readdata, .waitrequest, .tempValid,
	.tempValue, .queueReadPulse, .queueCfg, .alarmLimits, .alarmStatus, .irq);
`default_nettype wire

// ---- sim/sensor_config_alarm_regs_bench.sv ----
// self-checking bench for the sensor register bank
// assumes one 125 MHz clock and the bound checker alongside
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		nErrors++; \
		$display("wrong value at %0t: %h vs %h", $time, g, e); \
	end \
end
module sensor_config_alarm_regs_bench
	import sensor_regs_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic tempValid = 1'b0;
	logic signed [15:0] tempValue = 16'h0000;
	logic [5:0] queueFillCount = 6'h00;
	logic [7:0] queueData = 8'h00;
	logic [31:0] readdata;
	logic waitrequest;
	logic queueReadPulse;
	logic irq;
	queue_cfg_s queueCfg;
	limits_s alarmLimits;
	logic [7:0] alarmStatus;
	int nErrors = 0;
	int comparisons = 0;
	int seed = 55996;
	logic [31:0] q;
	logic [7:0] mk;
	logic signed [15:0] up, lo, t;
	logic [5:0] idxs [9] = '{6'h07, 6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10,
		6'h11, 6'h12, 6'h13};
	logic [15:0] cu [4] = '{16'h7fff, 16'h7fff, 16'h0000, 16'h0000};
	logic [15:0] cl [4] = '{16'h8000, 16'h8000, 16'h0000, 16'h0000};
	logic [15:0] ct [4] = '{16'h7fff, 16'h8000, 16'h0001, 16'hffff};
	always #4 ref_clk = ~ref_clk;
	sensor_config_alarm_regs #(.ADDR_WIDTH(8), .FILL_WIDTH(6)) dut (
		.ref_clk, .rst_n, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .tempValid, .tempValue, .queueFillCount, .queueData,
		.queueReadPulse, .queueCfg, .alarmLimits, .alarmStatus, .irq);
	task print_verdict;
		$display("checks %0d, errors %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one bus cycle, request held until waitrequest is seen low
	task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		writedata <= {24'h00_0000, d};
		read <= !wr;
		write <= wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		if (n >= 20) begin
			nErrors++;
			print_verdict();
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rd(input logic [5:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(q, {24'h00_0000, e})
	endtask
	function automatic logic [7:0] defVal(input logic [5:0] idx);
		case (idx)
			6'h07: defVal = {2'b00, queueFillCount};
			6'h08: defVal = queueData;
			6'h09: defVal = 8'h0f;
			6'h10: defVal = 8'h7f;
			6'h11: defVal = 8'hff;
			6'h12: defVal = 8'h80;
			default: defVal = 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] expStat(input logic signed [15:0] v, u, l);
		expStat = {5'b00000, v < l, v > u, 1'b0};
	endfunction
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		queueFillCount <= 6'($random(seed));
		queueData <= 8'($random(seed));
		@(posedge ref_clk);
		foreach (idxs[i]) rd(idxs[i], defVal(idxs[i]));
		bus(1'b1, 6'h09, 8'hff);
		rd(6'h09, 8'h1f);
		bus(1'b1, 6'h07, 8'h3f);
		bus(1'b1, 6'h3f, 8'h55);
		rd(6'h3f, 8'h00);
		rd(6'h07, {2'b00, queueFillCount});
		for (int i = 0; i < 24; i++) begin
			up = (i < 4) ? cu[i] : 16'($random(seed));
			lo = (i < 4) ? cl[i] : 16'($random(seed));
			t = (i < 4) ? ct[i] : 16'($random(seed));
			mk = i[0] ? 8'h06 : 8'h02;
			bus(1'b1, 6'h10, up[15:8]);
			bus(1'b1, 6'h11, up[7:0]);
			bus(1'b1, 6'h12, lo[15:8]);
			bus(1'b1, 6'h13, lo[7:0]);
			bus(1'b1, 6'h01, mk);
			`CHK(alarmLimits, {up, lo})
			rd(6'h12, lo[15:8]);
			rd(6'h11, up[7:0]);
			tempValue <= t;
			tempValid <= 1'b1;
			@(posedge ref_clk);
			tempValid <= 1'b0;
			@(posedge ref_clk);
			`CHK(alarmStatus, expStat(t, up, lo))
			`CHK(irq, |(expStat(t, up, lo) & mk))
			rd(6'h00, expStat(t, up, lo));
			`CHK(alarmStatus, 8'h00)
		end
		bus(1'b1, 6'h0a, 8'h1e);
		`CHK(queueCfg, 9'h1ff)
		rd(6'h01, 8'h06);
		bus(1'b1, 6'h0c, 8'h01);
		foreach (idxs[i]) rd(idxs[i], defVal(idxs[i]));
		rd(6'h01, 8'h00);
		`CHK(queueCfg, 9'h0f0)
		`CHK(alarmLimits, 32'h7fff_8000)
		print_verdict();
	end
endmodule
`default_nettype wire
